// *** design/vec_regs.svh ***
`ifndef VEC_REGS_SVH
`define VEC_REGS_SVH

// Status word bit positions.
`define FLAG_TF_BIT 4'h8
`define FLAG_IF_BIT 4'h9

// Types generated inside the block.
`define TYPE_DIV_ERR 8'h00
`define TYPE_STEP 8'h01
`define TYPE_NMI 8'h02

// Highest type held back for predefined uses.
`define TYPE_RSVD_TOP 8'h1F

// Table has this many entries, each four bytes wide.
`define TABLE_ENTRIES 16'h0100

// Stack word size and the span of the three saved words.
`define STACK_WORD 16'h0002
`define STACK_FRAME 16'h0006

// Offset of the segment half inside one table entry.
`define ENTRY_SEG_OFS 20'h0_0002

`endif

// *** design/vec_pkg.sv ***
package vec_pkg;

    typedef enum logic [11:0] {
        ST_IDLE   = 12'h001,
        ST_INTA   = 12'h002,
        ST_PSH_FL = 12'h004,
        ST_PSH_CS = 12'h008,
        ST_PSH_IP = 12'h010,
        ST_RD_IP  = 12'h020,
        ST_RD_CS  = 12'h040,
        ST_POP_IP = 12'h080,
        ST_POP_CS = 12'h100,
        ST_POP_FL = 12'h200,
        ST_RET    = 12'h400,
        ST_ENTER  = 12'h800
    } vec_state_t;

    typedef logic [7:0]  int_type_t;
    typedef logic [15:0] word_t;
    typedef logic [19:0] phys_addr_t;

endpackage : vec_pkg

// *** design/pin_sync.sv ***
`timescale 1ns/1ns

// Three-stage synchroniser; the level moves once stages two and three agree.
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    // Pin side
    input  wire logic [WIDTH-1:0] i_pin,
    // Clean level
    output logic      [WIDTH-1:0] o_level
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            level_r <= '0;
        end else begin
            for (int b = 0; b < WIDTH; b++) begin
                if (s2_r[b] == s3_r[b]) begin
                    level_r[b] <= s3_r[b];
                end
            end
        end
    end

    assign o_level = level_r;

endmodule : pin_sync

// *** design/interrupt_exception_vectoring.sv ***
`timescale 1ns/1ns
// Contract
// - Entry pushes status word, code segment and instruction pointer.
// - Service pointer table has up to 256 entries, one per type.
// - Types 0 to 31 are predefined; higher types are free.
// - Each source vectors through the entry at type times four.
// - Types are 8 bits; exceptions form theirs with no bus cycle.
// - Internal and non-cascaded requests take the internal controller type.
// - Cascaded maskable requests get their type in an acknowledge cycle.
// - Non-maskable requests use a fixed internal type, no acknowledge.
// - Software interrupts take any of 256 types from the instruction.
// - Hardware requests are sampled at instruction end; software goes first.
// - A high-priority request may preempt a routine with interrupts enabled.
// - Divide quotient overflow raises type zero.
// - Single-step flag raises type one after each instruction.
// - No step trap after prefixes, segment loads or the wait instruction.
// - Entry clears the single-step flag.
// - Interrupt return restores the step flag and resumes tracing.
// - Entry clears interrupt enable; saved word keeps the old value.
// - Non-maskable request ignores enable, uses type 2, no acknowledge.
// - Return restores flags; pending requests go before main-line code.

`include "vec_regs.svh"

module interrupt_exception_vectoring (
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_resetn,
    // Core state at the instruction boundary
    input  wire logic               i_instr_end,
    input  wire vec_pkg::word_t     i_flags,
    input  wire vec_pkg::word_t     i_cs,
    input  wire vec_pkg::word_t     i_next_ip,
    input  wire vec_pkg::word_t     i_ss,
    input  wire vec_pkg::word_t     i_sp,
    // Instruction events
    input  wire logic               i_div_overflow,
    input  wire logic               i_sw_int,
    input  wire vec_pkg::int_type_t i_sw_type,
    input  wire logic               i_step_inhibit,
    input  wire logic               i_interrupt_return_instr,
    // Hardware requests
    input  wire logic               i_nmi,
    input  wire logic               i_int_req,
    input  wire logic               i_int_cascade,
    input  wire vec_pkg::int_type_t i_int_type,
    output logic                    o_int_ack,
    // External acknowledge sequence
    output logic                    o_inta_n,
    input  wire logic               i_ext_ready,
    input  wire vec_pkg::int_type_t i_ext_vector,
    // Memory port
    output logic                    o_mem_req,
    output logic                    o_mem_we,
    output vec_pkg::phys_addr_t     o_mem_addr,
    output vec_pkg::word_t          o_mem_wdata,
    input  wire logic               i_mem_ack,
    input  wire vec_pkg::word_t     i_mem_rdata,
    // Core reload
    output logic                    o_busy,
    output logic                    o_load,
    output vec_pkg::word_t          o_new_cs,
    output vec_pkg::word_t          o_new_ip,
    output vec_pkg::word_t          o_new_flags,
    output vec_pkg::word_t          o_new_sp,
    output vec_pkg::int_type_t      o_type,
    output logic                    o_type_reserved
);
    import vec_pkg::*;

    vec_state_t state_r;
    vec_state_t state_nxt;
    int_type_t  type_r;
    int_type_t  type_nxt;
    word_t      sv_flags_r;
    word_t      sv_cs_r;
    word_t      sv_ip_r;
    word_t      ss_r;
    word_t      sp_r;
    word_t      new_ip_r;
    word_t      new_cs_r;
    word_t      new_flags_r;
    phys_addr_t addr_r;
    word_t      wdata_r;
    logic       load_r;
    logic       ack_r;
    logic       nmi_lvl;
    logic       nmi_seen_r;
    logic       nmi_pend_r;
    logic       ready_lvl;
    logic       nmi_rise;
    logic       take;
    logic       take_nmi;
    logic       take_inta;
    logic       take_int;
    word_t      arb_flags;
    logic       boundary;
    logic       chain;
    word_t      base_ss;
    word_t      base_sp;

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs.

    pin_sync #(
        .WIDTH (1)
    ) u_nmi_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_pin    (i_nmi),
        .o_level  (nmi_lvl)
    );

    pin_sync #(
        .WIDTH (1)
    ) u_ready_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_pin    (i_ext_ready),
        .o_level  (ready_lvl)
    );

    assign nmi_rise = nmi_lvl & ~nmi_seen_r;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            nmi_seen_r <= 1'b0;
        end else begin
            nmi_seen_r <= nmi_lvl;
        end
    end

    // A new edge in the clearing cycle keeps the request pending.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            nmi_pend_r <= 1'b0;
        end else begin
            nmi_pend_r <= nmi_rise | (nmi_pend_r & ~take_nmi);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbitration at an instruction boundary or after a return.

    assign boundary  = (state_r == ST_IDLE) & i_instr_end;
    assign chain     = (state_r == ST_RET);
    assign arb_flags = chain ? new_flags_r : i_flags;

    always_comb begin
        take      = 1'b0;
        take_nmi  = 1'b0;
        take_inta = 1'b0;
        take_int  = 1'b0;
        type_nxt  = type_r;
        if (boundary && i_div_overflow) begin
            take     = 1'b1;
            type_nxt = `TYPE_DIV_ERR;
        end else if (boundary && i_sw_int) begin
            take     = 1'b1;
            type_nxt = i_sw_type;
        end else if ((boundary || chain) && nmi_pend_r) begin
            take     = 1'b1;
            take_nmi = 1'b1;
            type_nxt = `TYPE_NMI;
        end else if ((boundary || chain) && i_int_req
                     && arb_flags[`FLAG_IF_BIT]) begin
            take = 1'b1;
            if (i_int_cascade) begin
                take_inta = 1'b1;
            end else begin
                take_int = 1'b1;
                type_nxt = i_int_type;
            end
        end else if (boundary && i_flags[`FLAG_TF_BIT]
                     && !i_step_inhibit) begin
            take     = 1'b1;
            type_nxt = `TYPE_STEP;
        end
        if ((state_r == ST_INTA) && ready_lvl) begin
            type_nxt = i_ext_vector;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = take_inta ? ST_INTA : ST_PSH_FL;
                end else if (i_interrupt_return_instr) begin
                    state_nxt = ST_POP_IP;
                end
            end
            ST_INTA: begin
                if (ready_lvl) begin
                    state_nxt = ST_PSH_FL;
                end
            end
            ST_PSH_FL: if (i_mem_ack) state_nxt = ST_PSH_CS;
            ST_PSH_CS: if (i_mem_ack) state_nxt = ST_PSH_IP;
            ST_PSH_IP: if (i_mem_ack) state_nxt = ST_RD_IP;
            ST_RD_IP:  if (i_mem_ack) state_nxt = ST_RD_CS;
            ST_RD_CS:  if (i_mem_ack) state_nxt = ST_ENTER;
            ST_POP_IP: if (i_mem_ack) state_nxt = ST_POP_CS;
            ST_POP_CS: if (i_mem_ack) state_nxt = ST_POP_FL;
            ST_POP_FL: if (i_mem_ack) state_nxt = ST_RET;
            ST_RET: begin
                state_nxt = take ? (take_inta ? ST_INTA : ST_PSH_FL)
                                 : ST_IDLE;
            end
            ST_ENTER:  state_nxt = ST_IDLE;
            default:   state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_r <= ST_IDLE;
            type_r  <= `TYPE_DIV_ERR;
        end else begin
            state_r <= state_nxt;
            type_r  <= type_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Saved context and stack pointer.

    assign base_ss = (state_r == ST_IDLE) ? i_ss : ss_r;
    assign base_sp = (state_r == ST_IDLE) ? i_sp : sp_r;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sv_flags_r <= '0;
            sv_cs_r    <= '0;
            sv_ip_r    <= '0;
        end else if (take) begin
            sv_flags_r <= chain ? new_flags_r : i_flags;
            sv_cs_r    <= chain ? new_cs_r : i_cs;
            sv_ip_r    <= chain ? new_ip_r : i_next_ip;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ss_r <= '0;
            sp_r <= '0;
        end else if ((state_r == ST_IDLE) && (take || i_interrupt_return_instr)) begin
            ss_r <= i_ss;
            sp_r <= i_sp;
        end else if ((state_r == ST_PSH_IP) && i_mem_ack) begin
            sp_r <= sp_r - `STACK_FRAME;
        end else if ((state_r == ST_POP_FL) && i_mem_ack) begin
            sp_r <= sp_r + `STACK_FRAME;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory addresses and write data, registered for the next state.

    function automatic phys_addr_t stk_addr(input word_t seg,
                                            input word_t ofs);
        stk_addr = {seg, 4'h0} + {4'h0, ofs};
    endfunction : stk_addr

    function automatic phys_addr_t vec_addr(input int_type_t t);
        vec_addr = {10'h000, t, 2'b00};
    endfunction : vec_addr

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            addr_r  <= '0;
            wdata_r <= '0;
        end else begin
            unique case (state_nxt)
                ST_PSH_FL: begin
                    addr_r  <= stk_addr(base_ss, base_sp - `STACK_WORD);
                    wdata_r <= chain ? new_flags_r
                             : (state_r == ST_IDLE) ? i_flags : sv_flags_r;
                end
                ST_PSH_CS: begin
                    addr_r  <= stk_addr(ss_r, sp_r - 16'h0004);
                    wdata_r <= sv_cs_r;
                end
                ST_PSH_IP: begin
                    addr_r  <= stk_addr(ss_r, sp_r - `STACK_FRAME);
                    wdata_r <= sv_ip_r;
                end
                ST_RD_IP: addr_r <= vec_addr(type_r);
                ST_RD_CS: begin
                    addr_r <= vec_addr(type_r) + `ENTRY_SEG_OFS;
                end
                ST_POP_IP: addr_r <= stk_addr(base_ss, base_sp);
                ST_POP_CS: addr_r <= stk_addr(ss_r, sp_r + `STACK_WORD);
                ST_POP_FL: addr_r <= stk_addr(ss_r, sp_r + 16'h0004);
                default: begin
                    addr_r  <= addr_r;
                    wdata_r <= wdata_r;
                end
            endcase
        end
    end

    assign o_mem_req = (state_r & (ST_PSH_FL | ST_PSH_CS | ST_PSH_IP
                       | ST_RD_IP | ST_RD_CS | ST_POP_IP | ST_POP_CS
                       | ST_POP_FL)) != 12'h000;
    assign o_mem_we  = (state_r & (ST_PSH_FL | ST_PSH_CS | ST_PSH_IP))
                       != 12'h000;

    ////////////////////////////////////////////////////////////////////////
    // New context for the core.

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            new_ip_r    <= '0;
            new_cs_r    <= '0;
            new_flags_r <= '0;
        end else begin
            if (take) begin
                new_flags_r <= arb_flags
                    & ~(16'h0001 << `FLAG_IF_BIT)
                    & ~(16'h0001 << `FLAG_TF_BIT);
            end
            if (i_mem_ack) begin
                unique case (state_r)
                    ST_RD_IP:  new_ip_r <= i_mem_rdata;
                    ST_RD_CS:  new_cs_r <= i_mem_rdata;
                    ST_POP_IP: new_ip_r <= i_mem_rdata;
                    ST_POP_CS: new_cs_r <= i_mem_rdata;
                    ST_POP_FL: new_flags_r <= i_mem_rdata;
                    default:   new_ip_r <= new_ip_r;
                endcase
            end
        end
    end

    // Reload pulses once entry finishes, or after a return that chains none.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            load_r <= 1'b0;
            ack_r  <= 1'b0;
        end else begin
            load_r <= ((state_r == ST_RD_CS) && i_mem_ack)
                      || (chain && !take);
            ack_r  <= take_int || take_nmi && 1'b0;
        end
    end

    assign o_int_ack       = ack_r;
    assign o_inta_n        = (state_r != ST_INTA);
    assign o_mem_addr      = addr_r;
    assign o_mem_wdata     = wdata_r;
    assign o_busy          = (state_r != ST_IDLE);
    assign o_load          = load_r;
    assign o_new_cs        = new_cs_r;
    assign o_new_ip        = new_ip_r;
    assign o_new_flags     = new_flags_r;
    assign o_new_sp        = sp_r;
    assign o_type          = type_r;
    assign o_type_reserved = (type_r <= `TYPE_RSVD_TOP);

endmodule : interrupt_exception_vectoring

// *** verification/interrupt_exception_vectoring_props.sv ***
`timescale 1ns/1ns

module interrupt_exception_vectoring_props (
    // Clock and reset
    input wire logic                i_clk,
    input wire logic                i_resetn,
    // Inputs
    input wire logic                i_instr_end,
    input wire vec_pkg::word_t      i_flags,
    input wire vec_pkg::word_t      i_ss,
    input wire vec_pkg::word_t      i_sp,
    input wire logic                i_div_overflow,
    input wire logic                i_sw_int,
    input wire vec_pkg::int_type_t  i_sw_type,
    input wire logic                i_mem_ack,
    input wire vec_pkg::word_t      i_mem_rdata,
    // Outputs
    input wire logic                o_int_ack,
    input wire logic                o_inta_n,
    input wire logic                o_mem_req,
    input wire logic                o_mem_we,
    input wire vec_pkg::phys_addr_t o_mem_addr,
    input wire vec_pkg::word_t      o_mem_wdata,
    input wire logic                o_load,
    input wire logic                o_busy,
    input wire vec_pkg::word_t      o_new_ip,
    input wire vec_pkg::word_t      o_new_flags,
    input wire vec_pkg::int_type_t  o_type,
    input wire logic                o_type_reserved
);
    import vec_pkg::*;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    logic  wrote_r;
    word_t ip_cap_r;
    wire   take_w = !o_busy && i_instr_end;
    wire   ie_w   = i_flags[9];

    // Marks an entry frame and keeps the word read from the entry low half.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wrote_r  <= 1'b0;
            ip_cap_r <= 16'h0000;
        end else begin
            if (o_load) begin
                wrote_r <= 1'b0;
            end else if (o_mem_req && o_mem_we && i_mem_ack) begin
                wrote_r <= 1'b1;
            end
            if (o_mem_req && !o_mem_we && i_mem_ack &&
                o_mem_addr == {10'h000, o_type, 2'b00}) begin
                ip_cap_r <= i_mem_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_take_div;
        take_w && i_div_overflow;
    endsequence
    sequence s_push_flags;
        o_mem_req && o_mem_we && o_mem_wdata == $past(i_flags) &&
        o_mem_addr == {$past(i_ss), 4'h0} + 20'($past(i_sp) - 16'h0002);
    endsequence
    sequence s_inta_low;
        !o_inta_n [*3];
    endsequence

    property p_first_push;
        s_take_div |=> s_push_flags;
    endproperty
    a_first_push: assert property (p_first_push)
        else $error("first push is not the status word below SP");
    property p_div_type;
        s_take_div |=> ##1 o_type == 8'h00 && o_inta_n;
    endproperty
    a_div_type: assert property (p_div_type)
        else $error("divide error type is not zero");
    property p_sw_type;
        take_w && i_sw_int && !i_div_overflow |=>
            ##1 o_type == $past(i_sw_type, 2);
    endproperty
    a_sw_type: assert property (p_sw_type)
        else $error("software type not taken from instruction");
    property p_mem_hold;
        o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) &&
            $stable(o_mem_wdata) && $stable(o_mem_we);
    endproperty
    a_mem_hold: assert property (p_mem_hold)
        else $error("memory request changed before ack");
    property p_entry_flags;
        o_load && wrote_r |-> o_new_flags[9:8] == 2'b00;
    endproperty
    a_entry_flags: assert property (p_entry_flags)
        else $error("entry left enable or step flag set");
    property p_vec_ip;
        o_load && wrote_r |-> o_new_ip == ip_cap_r;
    endproperty
    a_vec_ip: assert property (p_vec_ip)
        else $error("new pointer is not the entry low word");
    property p_rsvd;
        o_load |-> o_type_reserved == (o_type <= 8'h1F);
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved indication wrong");
    property p_ack_if;
        o_int_ack |-> $past(ie_w) && o_inta_n;
    endproperty
    a_ack_if: assert property (p_ack_if)
        else $error("maskable taken with enable clear");
    property p_inta;
        $fell(o_inta_n) |-> s_inta_low ##[1:30] o_inta_n;
    endproperty
    a_inta: assert property (p_inta)
        else $error("acknowledge low time out of range");
endmodule : interrupt_exception_vectoring_props

bind interrupt_exception_vectoring interrupt_exception_vectoring_props props_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_instr_end(i_instr_end),
    .i_flags(i_flags), .i_ss(i_ss), .i_sp(i_sp), .i_sw_int(i_sw_int),
    .i_div_overflow(i_div_overflow), .i_sw_type(i_sw_type),
    .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy),
    .o_int_ack(o_int_ack), .o_inta_n(o_inta_n), .o_mem_req(o_mem_req),
    .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_load(o_load),
    .o_mem_wdata(o_mem_wdata), .o_new_ip(o_new_ip), .o_type(o_type),
    .o_new_flags(o_new_flags), .o_type_reserved(o_type_reserved));

// *** verification/ext_int_ctrl.sv ***
`timescale 1ns/1ns

// Cascaded controller: answers a low acknowledge with ready and a type.
module ext_int_ctrl (
    input  wire logic               i_clk,
    input  wire logic               i_inta_n,
    input  wire logic [3:0]         i_delay,
    input  wire vec_pkg::int_type_t i_vector,
    output logic                    o_ready,
    output vec_pkg::int_type_t      o_vector
);
    logic [3:0] cnt_r = 4'h0;

    initial o_ready = 1'b0;
    initial o_vector = 8'h00;

    // A released vector bus toggles so a stale sample never matches.
    always @(posedge i_clk) begin
        if (i_inta_n) begin
            cnt_r    <= 4'h0;
            o_ready  <= 1'b0;
            o_vector <= ~o_vector;
        end else if (cnt_r == i_delay) begin
            o_ready  <= 1'b1;
            o_vector <= i_vector;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule : ext_int_ctrl

// *** verification/interrupt_exception_vectoring_tb.sv ***
`timescale 1ns/1ns

module interrupt_exception_vectoring_tb;
    import vec_pkg::*;

    logic       i_clk = 1'b0, i_resetn = 1'b0, i_instr_end = 1'b0;
    logic       i_div_overflow = 1'b0, i_sw_int = 1'b0, i_interrupt_return_instr = 1'b0;
    logic       i_step_inhibit = 1'b0, i_nmi = 1'b0, i_int_req = 1'b0;
    logic       i_int_cascade = 1'b0, i_mem_ack = 1'b0, inta_seen;
    word_t      i_flags = 16'h0000, i_cs = 16'h0000, i_next_ip = 16'h0000;
    word_t      i_ss = 16'h8000, i_sp = 16'h0100, i_mem_rdata = 16'h0000;
    int_type_t  i_sw_type = 8'h00, i_int_type = 8'h00, vec = 8'h00, tt;
    int_type_t  i_ext_vector, o_type;
    logic       i_ext_ready, o_int_ack, o_inta_n, o_mem_req, o_mem_we;
    logic       o_busy, o_load, o_type_reserved;
    phys_addr_t o_mem_addr;
    word_t      o_mem_wdata, o_new_cs, o_new_ip, o_new_flags, o_new_sp;
    word_t      fl, cs_x, ip_x, sp_x;
    word_t      mem [phys_addr_t];
    logic [3:0] dly = 4'h0;
    integer     seed = 32'h8268;
    int         error_cnt = 0, check_count = 0, ack_n, wt, mw = 0, k;

    always #50 i_clk = ~i_clk;

    interrupt_exception_vectoring dut_u (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_instr_end(i_instr_end),
        .i_flags(i_flags), .i_cs(i_cs), .i_next_ip(i_next_ip),
        .i_ss(i_ss), .i_sp(i_sp), .i_div_overflow(i_div_overflow),
        .i_sw_int(i_sw_int), .i_sw_type(i_sw_type), .i_interrupt_return_instr(i_interrupt_return_instr),
        .i_step_inhibit(i_step_inhibit), .i_nmi(i_nmi),
        .i_int_req(i_int_req), .i_int_cascade(i_int_cascade),
        .i_int_type(i_int_type), .o_int_ack(o_int_ack),
        .o_inta_n(o_inta_n), .i_ext_ready(i_ext_ready),
        .i_ext_vector(i_ext_vector), .o_mem_req(o_mem_req),
        .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack),
        .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_load(o_load),
        .o_new_cs(o_new_cs), .o_new_ip(o_new_ip), .o_type(o_type),
        .o_new_flags(o_new_flags), .o_new_sp(o_new_sp),
        .o_type_reserved(o_type_reserved));

    ext_int_ctrl ctrl_u (
        .i_clk(i_clk), .i_inta_n(o_inta_n), .i_delay(dly),
        .i_vector(vec), .o_ready(i_ext_ready), .o_vector(i_ext_vector));

    ////////////////////////////////////////////////////////////////////////
    function automatic word_t rd(input phys_addr_t a);
        return mem.exists(a) ? mem[a] : a[15:0] ^ 16'h3C5A;
    endfunction : rd

    function automatic word_t flg(input logic [1:0] b);
        return (16'($random(seed)) & 16'hFCFF) | {6'h00, b, 8'h00};
    endfunction : flg

    // Memory with a random wait of zero to three cycles per access.
    always @(posedge i_clk) begin
        ack_n += int'(o_int_ack === 1'b1);
        inta_seen |= (o_inta_n === 1'b0);
        i_mem_ack <= 1'b0;
        if (o_mem_req === 1'b1 && !i_mem_ack) begin
            if (mw == 0) begin
                if (o_mem_we) mem[o_mem_addr] = o_mem_wdata;
                i_mem_rdata <= rd(o_mem_addr);
                i_mem_ack <= 1'b1;
                mw = $random(seed) & 3;
            end else begin
                mw--;
            end
        end
    end

    task automatic fail(input logic bad, input string s);
        check_count++;
        if (bad) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, s);
        end
    endtask : fail

    task automatic chk_w(input word_t got, input word_t exp);
        fail(got !== exp, $sformatf("word %h expected %h", got, exp));
    endtask : chk_w

    task automatic chk_t(input int_type_t got, input int_type_t exp);
        fail(got !== exp, $sformatf("type %h expected %h", got, exp));
    endtask : chk_t

    task automatic chk_b(input logic got, input logic exp);
        fail(got !== exp, $sformatf("flag %b expected %b", got, exp));
    endtask : chk_b

    task automatic wait_load();
        for (wt = 0; wt < 300 && o_load !== 1'b1; wt++) @(negedge i_clk);
        chk_b(o_load, 1'b1);
    endtask : wait_load

    task automatic op(input logic [4:0] ev, input int_type_t t,
                      input int exp_t);
        @(posedge i_clk);
        cs_x = 16'($random(seed));
        ip_x = 16'($random(seed));
        sp_x = 16'($random(seed)) | 16'h0100;
        ack_n = 0;
        inta_seen = 1'b0;
        {i_int_cascade, i_int_req, i_step_inhibit, i_sw_int,
         i_div_overflow} <= ev;
        i_sw_type <= t;
        i_int_type <= ev[4] ? ~t : t;
        vec <= t;
        i_cs <= cs_x;
        i_next_ip <= ip_x;
        i_sp <= sp_x;
        i_flags <= fl;
        i_instr_end <= 1'b1;
        @(posedge i_clk);
        {i_int_cascade, i_int_req, i_step_inhibit, i_sw_int,
         i_div_overflow} <= 5'b00000;
        i_instr_end <= 1'b0;
        repeat (4) @(negedge i_clk);
        if (exp_t >= 0) begin
            wait_load();
            chk_t(o_type, 8'(exp_t));
            chk_b(o_type_reserved, exp_t < 32);
            chk_w(o_new_ip, rd(20'(exp_t * 4)));
            chk_w(o_new_cs, rd(20'(exp_t * 4 + 2)));
            chk_w(o_new_flags, fl & 16'hFCFF);
            chk_w(o_new_sp, sp_x - 16'h0006);
            chk_w(rd(20'h8_0000 + 20'(sp_x - 16'h0002)), fl);
            chk_w(rd(20'h8_0000 + 20'(sp_x - 16'h0004)), cs_x);
            chk_w(rd(20'h8_0000 + 20'(sp_x - 16'h0006)), ip_x);
            chk_b(ack_n == 1, ev == 5'b01000);
            chk_b(inta_seen, ev == 5'b11000);
            @(negedge i_clk);
        end
    endtask : op

    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        fl = flg(2'b00);
        op(5'b00001, 8'h00, 0);
        for (k = 0; k < 4; k++) begin
            tt = (k == 3) ? 8'hFF : 8'($random(seed));
            op(5'b00010, tt, tt);
        end
        fl = flg(2'b01);
        op(5'b00000, 8'h00, 1);
        @(posedge i_clk);
        i_sp <= sp_x - 16'h0006;
        i_interrupt_return_instr <= 1'b1;
        @(posedge i_clk);
        i_interrupt_return_instr <= 1'b0;
        wait_load();
        chk_w(o_new_flags, fl);
        chk_w(o_new_ip, ip_x);
        chk_w(o_new_cs, cs_x);
        chk_w(o_new_sp, sp_x);
        op(5'b00100, 8'h00, -1);
        chk_b(o_busy, 1'b0);
        fl = flg(2'b10);
        op(5'b01000, 8'h40, 8'h40);
        op(5'b01011, 8'h41, 0);
        op(5'b01010, 8'h42, 8'h42);
        for (k = 0; k < 2; k++) begin
            dly = 4'(k * 9);
            op(5'b11000, 8'h60 + 8'(k), 8'h60 + k);
        end
        fl = flg(2'b00);
        op(5'b01000, 8'h40, -1);
        chk_b(o_busy, 1'b0);
        @(posedge i_clk);
        i_nmi <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_nmi <= 1'b0;
        repeat (6) @(posedge i_clk);
        op(5'b00000, 8'h00, 2);
        results();
    end

    initial begin
        #3000000;
        error_cnt++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        results();
    end
endmodule : interrupt_exception_vectoring_tb
